// *** hw/zq_cal_controller.sv ***
// Controller end: issues calibration commands per channel within legal timing.
// Assumes user requests are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module zq_cal_controller (
	input wire logic clk,
	input wire logic resetn,
	zq_cal_if.controller link,
	input wire logic [1:0] req_start,
	input wire logic [1:0] req_latch,
	input wire logic [1:0] req_reset,
	input wire logic [1:0] in_powerdown,
	input wire logic [1:0] dq_idle,
	output logic [1:0] cal_pending,
	output logic [1:0] refused
);
	import zq_cal_pkg::*;

	logic [1:0] cal_busy, lat_busy, rst_busy;
	logic [1:0] cal_hold, lat_hold;
	logic [1:0] next_start, next_latch, next_reset, next_refused;
	logic shared_busy;

	genvar ch;
	generate
		for (ch = 0; ch < n_chan; ch++)
		begin : g_tmr
			zq_chan_timer u_tmr (
				.clk(clk),
				.resetn(resetn),
				.start_go(link.start_cmd[ch]),
				.latch_go(link.latch_cmd[ch]),
				.reset_go(link.reset_mrw[ch]),
				.cal_busy(cal_busy[ch]),
				.lat_busy(lat_busy[ch]),
				.rst_busy(rst_busy[ch])
			);
		end
	endgenerate

	always_comb
	begin
		// A command on the link counts as busy before its timer has loaded.
		cal_hold = cal_busy | link.start_cmd;
		lat_hold = lat_busy | link.latch_cmd;
		shared_busy = |cal_hold;
		for (int i = 0; i < n_chan; i++)
		begin
			next_start[i] = req_start[i] && !in_powerdown[i] && !shared_busy
				&& !lat_hold[i];
			next_latch[i] = req_latch[i] && !in_powerdown[i] && !cal_hold[i]
				&& dq_idle[i] && !lat_hold[i];
			next_reset[i] = req_reset[i] && !cal_hold[i] && !lat_hold[i];
			next_refused[i] = (req_start[i] && !next_start[i]) ||
				(req_latch[i] && !next_latch[i]) || (req_reset[i] && !next_reset[i]);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			link.start_cmd <= 2'h0;
			link.latch_cmd <= 2'h0;
			link.reset_mrw <= 2'h0;
			link.mrw_op <= 8'h00;
			link.powerdown <= 2'h0;
			link.ca_deselect <= 2'h3;
			refused <= 2'h0;
			cal_pending <= 2'h0;
		end
		else
		begin
			link.start_cmd <= next_start;
			link.latch_cmd <= next_latch;
			link.reset_mrw <= next_reset;
			link.mrw_op <= {7'h00, |next_reset};
			link.powerdown <= in_powerdown;
			link.ca_deselect <= lat_hold | ~(next_start | next_latch | next_reset);
			refused <= next_refused;
			cal_pending <= cal_busy | rst_busy;
		end
	end
endmodule : zq_cal_controller
`default_nettype wire

// *** hw/zq_cal_device.sv ***
// Device end: one calibration engine shared by two channels.
// Assumes the controller keeps its ordering and timing duties.
`timescale 1ns/1ps
`default_nettype none
module zq_cal_device (
	input wire logic clk,
	input wire logic resetn,
	zq_cal_if.device link,
	input wire logic [zq_cal_pkg::code_w-1:0] engine_code,
	output logic cal_in_progress,
	output logic [zq_cal_pkg::code_w-1:0] completed_code,
	output logic [zq_cal_pkg::code_w-1:0] drive_code_ch0,
	output logic [zq_cal_pkg::code_w-1:0] drive_code_ch1,
	output logic [1:0] reset_done
);
	import zq_cal_pkg::*;

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	logic [1:0] take_start;
	logic [1:0] take_latch;
	logic [1:0] take_reset;

	always_comb
	begin
		for (int i = 0; i < n_chan; i++)
		begin
			// A start or latch counts only while its channel is selected and awake; a reset needs selection and the op bit, not awake.
			take_start[i] = link.start_cmd[i] && !link.ca_deselect[i] && !link.powerdown[i];
			take_latch[i] = link.latch_cmd[i] && !link.ca_deselect[i] && !link.powerdown[i];
			take_reset[i] = link.reset_mrw[i] && !link.ca_deselect[i]
				&& link.mrw_op[reset_op_bit];
		end
	end

	// ------------------------------------------------------------
	// Engine result synchroniser
	// ------------------------------------------------------------
	code_t code_meta, code_sync;
	code_t next_code_meta, next_code_sync;

	always_comb
	begin
		// The analog result settles long before a run ends, so the word is stable when used.
		next_code_meta = engine_code;
		next_code_sync = code_meta;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			code_meta <= code_default;
			code_sync <= code_default;
		end
		else
		begin
			code_meta <= next_code_meta;
			code_sync <= next_code_sync;
		end
	end

	// ------------------------------------------------------------
	// Engine state
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_run = 2'b10
	} eng_state_t;

	eng_state_t state, next_state;
	cnt_t cal_cnt, next_cal_cnt;
	code_t next_completed;
	logic next_busy;
	logic any_start;

	always_comb
	begin
		any_start = |take_start;
		next_state = state;
		next_cal_cnt = cal_cnt;
		next_completed = completed_code;
		unique case (state)
			st_idle:
			begin
				if (any_start)
				begin
					next_state = st_run;
					next_cal_cnt = cal_cycles;
				end
			end
			st_run:
			begin
				// Further starts are ignored while running.
				if (cal_cnt == cnt_one)
				begin
					next_state = st_idle;
					next_cal_cnt = cnt_zero;
					next_completed = code_sync;
				end
				else
				begin
					next_cal_cnt = cal_cnt - cnt_one;
				end
			end
		endcase
		next_busy = (next_state == st_run);
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state <= st_idle;
			cal_cnt <= cnt_zero;
			completed_code <= code_default;
			cal_in_progress <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cal_cnt <= next_cal_cnt;
			completed_code <= next_completed;
			cal_in_progress <= next_busy;
		end
	end

	// ------------------------------------------------------------
	// Per-channel driver codes
	// ------------------------------------------------------------
	code_t drive [n_chan];
	code_t next_drive [n_chan];
	cnt_t rst_cnt [n_chan];
	cnt_t next_rst_cnt [n_chan];
	logic [1:0] next_reset_done;

	genvar ch;
	generate
		for (ch = 0; ch < n_chan; ch++)
		begin : g_chan
			always_comb
			begin
				next_drive[ch] = drive[ch];
				next_rst_cnt[ch] = rst_cnt[ch];
				next_reset_done[ch] = 1'b0;
				if (take_reset[ch])
				begin
					next_drive[ch] = code_default;
					next_rst_cnt[ch] = rst_cycles;
				end
				else if (take_latch[ch])
				begin
					// Result of the last finished run; a timely latch sees the newest.
					next_drive[ch] = completed_code;
				end
				if (rst_cnt[ch] == cnt_one)
				begin
					next_reset_done[ch] = 1'b1;
				end
				if (rst_cnt[ch] != cnt_zero)
				begin
					next_rst_cnt[ch] = rst_cnt[ch] - cnt_one;
				end
			end

			always_ff @(posedge clk)
			begin
				if (!resetn)
				begin
					drive[ch] <= code_default;
					rst_cnt[ch] <= cnt_zero;
					reset_done[ch] <= 1'b0;
				end
				else
				begin
					drive[ch] <= next_drive[ch];
					rst_cnt[ch] <= next_rst_cnt[ch];
					reset_done[ch] <= next_reset_done[ch];
				end
			end
		end
	endgenerate

	// Engine never gates channel traffic; nothing here stalls other commands.
	assign drive_code_ch0 = drive[0];
	assign drive_code_ch1 = drive[1];
endmodule : zq_cal_device
`default_nettype wire

// *** hw/zq_cal_if.sv ***
// Command link between a memory controller and a two-channel calibration die.
// Assumes both ends share clk; commands are one-cycle pulses per channel.
`timescale 1ns/1ps
`default_nettype none
interface zq_cal_if;
	logic [1:0] start_cmd;
	logic [1:0] latch_cmd;
	logic [1:0] reset_mrw;
	logic [7:0] mrw_op;
	logic [1:0] powerdown;
	logic [1:0] ca_deselect;

	modport device (
		input start_cmd,
		input latch_cmd,
		input reset_mrw,
		input mrw_op,
		input powerdown,
		input ca_deselect
	);

	modport controller (
		output start_cmd,
		output latch_cmd,
		output reset_mrw,
		output mrw_op,
		output powerdown,
		output ca_deselect
	);
endinterface : zq_cal_if
`default_nettype wire

// *** hw/zq_cal_pkg.sv ***
// Shared constants and types for the impedance-calibration sequencer pair.
// Assumes a single 200 MHz command clock shared by both ends.
package zq_cal_pkg;

	localparam int unsigned clk_period_ps = 5000;
	localparam int unsigned calibration_time_ns = 1000;
	localparam int unsigned latch_period_ns = 30;
	localparam int unsigned latch_period_min_ck = 8;
	localparam int unsigned reset_completion_time_ns = 50;
	localparam int unsigned reset_completion_min_ck = 3;

	localparam int unsigned cal_cycles_raw = (calibration_time_ns * 1000 + clk_period_ps - 1)
		/ clk_period_ps;
	localparam int unsigned lat_ns_cycles = (latch_period_ns * 1000 + clk_period_ps - 1)
		/ clk_period_ps;
	localparam int unsigned lat_cycles_raw = (lat_ns_cycles > latch_period_min_ck) ?
		lat_ns_cycles : latch_period_min_ck;
	localparam int unsigned rst_ns_cycles = (reset_completion_time_ns * 1000 + clk_period_ps - 1)
		/ clk_period_ps;
	localparam int unsigned rst_cycles_raw = (rst_ns_cycles > reset_completion_min_ck) ?
		rst_ns_cycles : reset_completion_min_ck;

	localparam int cnt_w = 10;
	localparam int code_w = 8;
	localparam int n_chan = 2;

	localparam logic [cnt_w-1:0] cal_cycles = cnt_w'(cal_cycles_raw);
	localparam logic [cnt_w-1:0] lat_cycles = cnt_w'(lat_cycles_raw);
	localparam logic [cnt_w-1:0] rst_cycles = cnt_w'(rst_cycles_raw);
	localparam logic [cnt_w-1:0] cnt_zero = 10'h000;
	localparam logic [cnt_w-1:0] cnt_one = 10'h001;

	localparam logic [code_w-1:0] code_default = 8'h80;
	localparam logic [code_w-1:0] code_step = 8'h01;
	localparam int reset_op_bit = 0;

	typedef logic [cnt_w-1:0] cnt_t;
	typedef logic [code_w-1:0] code_t;

endpackage : zq_cal_pkg

// *** hw/zq_chan_timer.sv ***
// Per-channel timekeeping for the controller end.
// Assumes one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module zq_chan_timer (
	input wire logic clk,
	input wire logic resetn,
	input wire logic start_go,
	input wire logic latch_go,
	input wire logic reset_go,
	output logic cal_busy,
	output logic lat_busy,
	output logic rst_busy
);
	import zq_cal_pkg::*;

	zq_cal_pkg::cnt_t cal_cnt, lat_cnt, rst_cnt;
	zq_cal_pkg::cnt_t next_cal_cnt, next_lat_cnt, next_rst_cnt;

	always_comb
	begin
		next_cal_cnt = start_go ? cal_cycles : ((cal_cnt != cnt_zero) ? cal_cnt - cnt_one : cal_cnt);
		next_lat_cnt = latch_go ? lat_cycles : ((lat_cnt != cnt_zero) ? lat_cnt - cnt_one : lat_cnt);
		next_rst_cnt = reset_go ? rst_cycles : ((rst_cnt != cnt_zero) ? rst_cnt - cnt_one : rst_cnt);
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			cal_cnt <= cnt_zero;
			lat_cnt <= cnt_zero;
			rst_cnt <= cnt_zero;
		end
		else
		begin
			cal_cnt <= next_cal_cnt;
			lat_cnt <= next_lat_cnt;
			rst_cnt <= next_rst_cnt;
		end
	end

	assign cal_busy = (cal_cnt != cnt_zero);
	assign lat_busy = (lat_cnt != cnt_zero);
	assign rst_busy = (rst_cnt != cnt_zero);
endmodule : zq_chan_timer
`default_nettype wire

// *** tb/zq_cal_checker.sv ***
// Concurrent checks on the calibration link between the two ends.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module zq_cal_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [1:0] start_cmd,
	input wire logic [1:0] latch_cmd,
	input wire logic [1:0] reset_mrw,
	input wire logic [7:0] mrw_op,
	input wire logic [1:0] powerdown,
	input wire logic [1:0] ca_deselect
);
	import zq_cal_pkg::*;
	int gap;
	int since [2];
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// ----------------------------------------
	// Cycles since the last start, per channel and overall.
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		gap <= (!resetn) ? 1000 : ((start_cmd != 2'h0) ? 1 : gap + 1);
		for (int i = 0; i < 2; i++)
			since[i] <= (!resetn) ? 1000 : (start_cmd[i] ? 1 : since[i] + 1);
	end
	for (genvar i = 0; i < 2; i++)
	begin : g_ch
		sequence s_desel;
			ca_deselect[i] [*8];
		endsequence
		sequence s_quiet;
			(!latch_cmd[i] && !start_cmd[i]) [*7];
		endsequence
		a_latch_deselect: assert property (latch_cmd[i] |=> s_desel)
			else $error("command bus not deselected in latch period");
		a_latch_quiet: assert property (latch_cmd[i] |=> s_quiet)
			else $error("command issued in latch period");
		a_start_awake: assert property (start_cmd[i] |-> !powerdown[i])
			else $error("start sent in power-down");
		a_latch_awake: assert property (latch_cmd[i] |-> !powerdown[i])
			else $error("latch sent in power-down");
		a_latch_wait: assert property (latch_cmd[i] |-> since[i] >= cal_cycles)
			else $error("latch sent before calibration time");
		a_reset_wait: assert property (reset_mrw[i] |-> since[i] >= cal_cycles)
			else $error("mode write during calibration");
	end
	a_start_gap: assert property (start_cmd != 2'h0 |-> gap >= cal_cycles)
		else $error("calibrations overlap");
	a_reset_op: assert property (reset_mrw != 2'h0 |-> mrw_op[reset_op_bit])
		else $error("reset write without bit zero set");
endmodule : zq_cal_checker
`default_nettype wire

// *** tb/zq_calibration_sequencer_tb.sv ***
// Self-checking bench joining the controller end to the device end.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
`default_nettype none
module zq_calibration_sequencer_tb;
	import zq_cal_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [1:0] rs = 2'h0, rl = 2'h0, rr = 2'h0, pd = 2'h0, idle = 2'h3;
	code_t eng = 8'h00;
	code_t done_c, d0, d1;
	logic busy;
	logic [1:0] rdone, pend, refd;
	int err_total = 0, n_checks = 0, cyc = 0;
	zq_cal_if link ();
	zq_cal_controller zq_cal_controller_inst (.clk(clk), .resetn(resetn), .link(link),
		.req_start(rs), .req_latch(rl), .req_reset(rr), .in_powerdown(pd),
		.dq_idle(idle), .cal_pending(pend), .refused(refd));
	zq_cal_device zq_cal_device_inst (.clk(clk), .resetn(resetn), .link(link),
		.engine_code(eng), .cal_in_progress(busy), .completed_code(done_c),
		.drive_code_ch0(d0), .drive_code_ch1(d1), .reset_done(rdone));
	zq_cal_checker zq_cal_checker_inst (.clk(clk), .resetn(resetn),
		.start_cmd(link.start_cmd), .latch_cmd(link.latch_cmd),
		.reset_mrw(link.reset_mrw), .mrw_op(link.mrw_op),
		.powerdown(link.powerdown), .ca_deselect(link.ca_deselect));
	always #2.5 clk = ~clk;
	// ----------------------------------------
	// Tasks.
	// ----------------------------------------
	task chk(input string nm, input code_t e, input code_t g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task go(input logic [1:0] s, input logic [1:0] l, input logic [1:0] r,
		output logic [1:0] ref_o);
		ref_o = 2'h0;
		@(posedge clk);
		rs <= s;
		rl <= l;
		rr <= r;
		@(posedge clk);
		rs <= 2'h0;
		rl <= 2'h0;
		rr <= 2'h0;
		repeat (4)
		begin
			@(negedge clk);
			ref_o = ref_o | refd;
		end
	endtask : go
	task wait_busy(input logic v);
		for (int k = 0; k < 300 && busy !== v; k++)
			@(negedge clk);
		chk("busy", {7'h00, v}, {7'h00, busy});
	endtask : wait_busy
	task stop_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			stop_test();
		end
	end
	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial
	begin
		logic [1:0] r;
		int k;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		eng <= 8'h5A;
		@(negedge clk);
		chk("drive0", code_default, d0);
		chk("drive1", code_default, d1);
		go(2'h3, 2'h0, 2'h0, r);
		chk("refused", 8'h00, {6'h00, r});
		chk("busy", 8'h01, {7'h00, busy});
		chk("pending", 8'h03, {6'h00, pend});
		go(2'h1, 2'h0, 2'h0, r);
		chk("refused", 8'h01, {6'h00, r});
		go(2'h0, 2'h2, 2'h1, r);
		chk("refused", 8'h03, {6'h00, r});
		chk("drive1", code_default, d1);
		wait_busy(1'b0);
		chk("completed", 8'h5A, done_c);
		chk("drive0", code_default, d0);
		go(2'h0, 2'h1, 2'h0, r);
		chk("drive0", 8'h5A, d0);
		chk("drive1", code_default, d1);
		go(2'h0, 2'h2, 2'h0, r);
		chk("drive1", 8'h5A, d1);
		@(posedge clk);
		pd <= 2'h1;
		idle <= 2'h1;
		go(2'h1, 2'h2, 2'h0, r);
		chk("refused", 8'h03, {6'h00, r});
		@(posedge clk);
		pd <= 2'h0;
		idle <= 2'h3;
		eng <= 8'h33;
		go(2'h0, 2'h0, 2'h1, r);
		chk("drive0", code_default, d0);
		chk("drive1", 8'h5A, d1);
		chk("pending", 8'h01, {6'h00, pend});
		for (k = 0; k < 20 && rdone[0] !== 1'b1; k++)
			@(negedge clk);
		chk("reset_done", 8'h01, {6'h00, rdone});
		go(2'h2, 2'h0, 2'h0, r);
		wait_busy(1'b1);
		wait_busy(1'b0);
		chk("completed", 8'h33, done_c);
		go(2'h0, 2'h3, 2'h0, r);
		chk("drive0", 8'h33, d0);
		chk("drive1", 8'h33, d1);
		stop_test();
	end
endmodule : zq_calibration_sequencer_tb
`default_nettype wire
